// >>> hw/qoc_pkg.sv
// Purpose: Constants for the per-interface QoS override and control register bank.
// Assumes: Word-indexed register port, one 32-bit word per register.
// Notes: Offsets are local choices; each interface owns a block of four words.
//
// How it works
// - Read override field forces read QoS value
// - Write override field forces write QoS value
// - Override applies when forced and regulator off
// - Bits 11:8 report current regulated value, read-only
// - Non-secure accesses refused unless permission set
// - Control bit 31 reports regulation support
// - Without support control register has no effect
// - Bit 21 selects normal or quiesce-high
// - Normal holds value idle, quiesce-high drifts up
// - Bit 20 selects read latency or period
// - Bit 16 selects write latency or period
// - Bit 3 read outstanding enable, lite only
// - Bit 2 write outstanding enable, lite only
// - Bit 1 enables read value regulation
// - Bit 0 enables write value regulation
// - Outstanding enable change waits until its channel has no transactions outstanding
package qoc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned QOC_IF_STRIDE = 4; // Words per interface block
  localparam logic [1:0] QOC_OFS_RD_OVR = 2'h0; // read_qos_override
  localparam logic [1:0] QOC_OFS_WR_OVR = 2'h1; // write_qos_override
  localparam logic [1:0] QOC_OFS_CTRL = 2'h2; // qos_regulation_control
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned QOC_OVR_LO = 0; // Override value [3:0]
  localparam int unsigned QOC_CUR_LO = 8; // Current value [11:8]
  localparam int unsigned QOC_QW = 4; // QoS width
  localparam int unsigned QOC_B_SUPP = 31;
  localparam int unsigned QOC_B_QHIGH = 21;
  localparam int unsigned QOC_B_RPER = 20;
  localparam int unsigned QOC_B_WPER = 16;
  localparam int unsigned QOC_B_ROT = 3;
  localparam int unsigned QOC_B_WOT = 2;
  localparam int unsigned QOC_B_RQV = 1;
  localparam int unsigned QOC_B_WQV = 0;
  // ----------------------------------------------------------------
  // Reset, limit and idle step values
  // ----------------------------------------------------------------
  localparam logic [3:0] QOC_QOS_RST = 4'h0;
  localparam logic [3:0] QOC_QOS_MAX = 4'hF;
  localparam logic [31:0] QOC_RAZ = 32'h0000_0000;
  localparam int unsigned QOC_IDLE_STEP = 16; // Idle cycles per quiesce-high step
endpackage

// >>> hw/qoc_chan.sv
// Purpose: One channel (read or write) of one interface: override field, current value, QoS select.
// Assumes: Regulator arithmetic is outside; its value arrives on reg_qos.
// Notes: In quiesce-high mode the reported value climbs while the master is idle.
`timescale 1ns/10ps
module qoc_chan
  import qoc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ovr_we, // Write strobe for the override field
  input wire logic [3:0] ovr_wdata, // Write data for the override field
  input wire logic force_in, // Synchronised force input
  input wire logic reg_en, // Value regulation enabled
  input wire logic qhigh, // Quiesce-high mode
  input wire logic idle, // Master has no traffic on this channel
  input wire logic [3:0] reg_qos, // Regulator value
  input wire logic [3:0] req_qos, // QoS arriving with the request
  output logic [3:0] ovr_ff, // Stored override field
  output logic [3:0] cur_ff, // Value applied to QoS-zero requests
  output logic [3:0] out_qos // QoS forwarded downstream
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [4:0] idle_cnt_ff; // Idle cycle counter for drifting
  logic [4:0] nxt_idle_cnt;
  logic [3:0] nxt_cur;
  logic step; // Drift one step now
  logic regulating; // Force high and regulator on
  assign regulating = force_in & reg_en;
  assign step = qhigh & idle & (idle_cnt_ff == 5'(QOC_IDLE_STEP - 1));
  assign nxt_idle_cnt = (qhigh & idle & ~step) ? idle_cnt_ff + 5'h01 : 5'h00;
  // Normal mode tracks the regulator while busy and holds when idle; quiesce-high drifts toward max when idle
  assign nxt_cur = ~regulating ? QOC_QOS_RST :
                   (qhigh & idle) ? ((step && cur_ff != QOC_QOS_MAX) ? cur_ff + 4'h1 : cur_ff) :
                   (idle ? cur_ff : reg_qos);
  // Override wins only while forced and unregulated
  assign out_qos = (force_in & ~reg_en) ? ovr_ff :
                   (regulating && req_qos == 4'h0) ? cur_ff : req_qos;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Override field and regulator tracking
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_ff <= QOC_QOS_RST;
      cur_ff <= QOC_QOS_RST;
      idle_cnt_ff <= 5'h00;
    end else begin
      if (ovr_we) begin
        ovr_ff <= ovr_wdata;
      end
      cur_ff <= nxt_cur;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ovr_select_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (force_in && !reg_en) |-> out_qos == ovr_ff) else $error("override not applied");
  cur_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !regulating |=> cur_ff == QOC_QOS_RST) else $error("current value not cleared");
  idle_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (regulating && !qhigh && idle) ##1 (regulating && !qhigh && idle) |-> $stable(cur_ff))
    else $error("value moved while idle in normal mode");
endmodule

// >>> hw/qoc_regs.sv
// Purpose: QoS override and control registers for a set of slave interfaces.
// Assumes: Register port with read data one cycle after the read strobe; force pins are asynchronous.
// Notes: Interface i uses word addresses i*4 + offset; unmapped words read zero.
`timescale 1ns/10ps
module qoc_regs
  import qoc_pkg::*;
#(
  parameter int unsigned N_IF = 5, // Number of slave interfaces
  parameter logic [4:0] LITE_MASK = 5'h07, // Interfaces with lite protocol
  parameter logic QOS_SUPPORTED = 1'b1 // Regulation present in this build
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr, // Word address
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic reg_secure, // Access is secure
  input wire logic nonsec_allow, // Non-secure access permitted
  output logic [31:0] reg_rdata_ff, // Read data, one cycle after strobe
  input wire logic [4:0] qos_force_input, // Per-interface force pins
  input wire logic [4:0] rd_idle, // Read channel idle per interface
  input wire logic [4:0] wr_idle, // Write channel idle per interface
  input wire logic [4:0] rd_none_out, // No reads outstanding
  input wire logic [4:0] wr_none_out, // No writes outstanding
  input wire logic [19:0] rd_reg_qos, // Regulator read value per interface
  input wire logic [19:0] wr_reg_qos, // Regulator write value per interface
  input wire logic [19:0] rd_req_qos, // Incoming read QoS per interface
  input wire logic [19:0] wr_req_qos, // Incoming write QoS per interface
  output logic [19:0] rd_out_qos, // Forwarded read QoS
  output logic [19:0] wr_out_qos, // Forwarded write QoS
  output logic [4:0] rd_ot_en, // Outstanding-read regulation in force
  output logic [4:0] wr_ot_en, // Outstanding-write regulation in force
  output logic [4:0] qhigh_mode, // Quiesce-high per interface
  output logic [4:0] rd_period_mode, // Read regulator period mode
  output logic [4:0] wr_period_mode // Write regulator period mode
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] force_meta_ff; // First stage, read only by second
  logic [4:0] force_ff; // Synchronised force pins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      force_meta_ff <= 5'h00;
      force_ff <= 5'h00;
    end else begin
      force_meta_ff <= qos_force_input;
      force_ff <= force_meta_ff;
    end
  end
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic access_ok; // Security check passes
  logic wr_ok;
  logic [2:0] sel_if; // Addressed interface
  logic [1:0] sel_ofs; // Word within the block
  logic sel_valid; // Interface exists
  assign access_ok = reg_secure | nonsec_allow;
  assign wr_ok = reg_wr & access_ok;
  assign sel_if = reg_addr[4:2];
  assign sel_ofs = reg_addr[1:0];
  assign sel_valid = 32'(sel_if) < N_IF;
  // ----------------------------------------------------------------
  // Per-interface storage
  // ----------------------------------------------------------------
  logic [31:0] word_rd [N_IF][3]; // Read view of each register
  logic [5:0] ctrl_ff [N_IF]; // {qhigh, rper, wper, rqv, wqv, pad}
  logic [1:0] ot_req_ff [N_IF]; // Programmed {rot, wot}
  logic [1:0] ot_act_ff [N_IF]; // Enables in force {rot, wot}
  genvar g;
  for (g = 0; g < N_IF; g++) begin : g_if
    logic hit; // Interface addressed by a valid write
    logic ctrl_we;
    logic lite; // Lite protocol interface
    logic [3:0] rd_ovr;
    logic [3:0] wr_ovr;
    logic [3:0] rd_cur;
    logic [3:0] wr_cur;
    logic [1:0] nxt_ot_req;
    logic [1:0] nxt_ot_act;
    assign lite = LITE_MASK[g];
    assign hit = wr_ok & sel_valid & (32'(sel_if) == g);
    assign ctrl_we = hit & (sel_ofs == QOC_OFS_CTRL) & QOS_SUPPORTED;
    // Full coherent interfaces keep the outstanding enables at zero
    assign nxt_ot_req = ctrl_we ? ({reg_wdata[QOC_B_ROT], reg_wdata[QOC_B_WOT]} & {2{lite}}) :
                        ot_req_ff[g];
    // Each enable follows its request only when that channel has drained
    assign nxt_ot_act[1] = rd_none_out[g] ? ot_req_ff[g][1] : ot_act_ff[g][1];
    assign nxt_ot_act[0] = wr_none_out[g] ? ot_req_ff[g][0] : ot_act_ff[g][0];
    // Control register writes
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_ff[g] <= 6'h00;
        ot_req_ff[g] <= 2'h0;
        ot_act_ff[g] <= 2'h0;
      end else begin
        if (ctrl_we) begin
          ctrl_ff[g] <= {reg_wdata[QOC_B_QHIGH], reg_wdata[QOC_B_RPER], reg_wdata[QOC_B_WPER],
                         reg_wdata[QOC_B_RQV], reg_wdata[QOC_B_WQV], 1'b0};
        end
        ot_req_ff[g] <= nxt_ot_req;
        ot_act_ff[g] <= nxt_ot_act;
      end
    end
    qoc_chan u_rd (
      .mclk(mclk),
      .rst_n(rst_n),
      .ovr_we(hit & (sel_ofs == QOC_OFS_RD_OVR)),
      .ovr_wdata(reg_wdata[QOC_OVR_LO +: QOC_QW]),
      .force_in(force_ff[g]),
      .reg_en(ctrl_ff[g][2]),
      .qhigh(ctrl_ff[g][5]),
      .idle(rd_idle[g]),
      .reg_qos(rd_reg_qos[g*4 +: 4]),
      .req_qos(rd_req_qos[g*4 +: 4]),
      .ovr_ff(rd_ovr),
      .cur_ff(rd_cur),
      .out_qos(rd_out_qos[g*4 +: 4])
    );
    qoc_chan u_wr (
      .mclk(mclk),
      .rst_n(rst_n),
      .ovr_we(hit & (sel_ofs == QOC_OFS_WR_OVR)),
      .ovr_wdata(reg_wdata[QOC_OVR_LO +: QOC_QW]),
      .force_in(force_ff[g]),
      .reg_en(ctrl_ff[g][1]),
      .qhigh(ctrl_ff[g][5]),
      .idle(wr_idle[g]),
      .reg_qos(wr_reg_qos[g*4 +: 4]),
      .req_qos(wr_req_qos[g*4 +: 4]),
      .ovr_ff(wr_ovr),
      .cur_ff(wr_cur),
      .out_qos(wr_out_qos[g*4 +: 4])
    );
    // Read views; everything else reads zero
    assign word_rd[g][0] = {20'h00000, rd_cur, 4'h0, rd_ovr};
    assign word_rd[g][1] = {20'h00000, wr_cur, 4'h0, wr_ovr};
    assign word_rd[g][2] = QOS_SUPPORTED ?
                           {1'b1, 9'h000, ctrl_ff[g][5], ctrl_ff[g][4], 3'h0, ctrl_ff[g][3],
                            12'h000, ot_req_ff[g], ctrl_ff[g][2], ctrl_ff[g][1]} : QOC_RAZ;
    assign rd_ot_en[g] = ot_act_ff[g][1];
    assign wr_ot_en[g] = ot_act_ff[g][0];
    assign qhigh_mode[g] = ctrl_ff[g][5];
    assign rd_period_mode[g] = ctrl_ff[g][4];
    assign wr_period_mode[g] = ctrl_ff[g][3];
    // Checks
    ot_lite_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !lite |-> ot_req_ff[g] == 2'h0) else $error("outstanding enable on coherent port");
    ot_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (!rd_none_out[g] ##1 1'b1) |-> $stable(ot_act_ff[g][1])) else $error("read enable changed busy");
    ot_take_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_none_out[g] |=> ot_act_ff[g][0] == $past(ot_req_ff[g][0])) else $error("write enable not taken");
  end
  for (g = N_IF; g < 5; g++) begin : g_pad
    assign rd_out_qos[g*4 +: 4] = 4'h0;
    assign wr_out_qos[g*4 +: 4] = 4'h0;
    assign rd_ot_en[g] = 1'b0;
    assign wr_ot_en[g] = 1'b0;
    assign qhigh_mode[g] = 1'b0;
    assign rd_period_mode[g] = 1'b0;
    assign wr_period_mode[g] = 1'b0;
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] rd_sel; // Word selected by the address
  assign rd_sel = (!access_ok || !sel_valid || sel_ofs == 2'h3) ? QOC_RAZ : word_rd[sel_if][sel_ofs];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= QOC_RAZ;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_sel : QOC_RAZ;
    end
  end
  sec_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && !reg_secure && !nonsec_allow) |=> reg_rdata_ff == QOC_RAZ) else $error("non-secure read leaked");
  supp_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_rd && access_ok && sel_valid && sel_ofs == QOC_OFS_CTRL) |=> reg_rdata_ff[QOC_B_SUPP] == QOS_SUPPORTED)
    else $error("support bit wrong");
  rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rdata_ff[30:22] == 9'h000 && reg_rdata_ff[15:12] == 4'h0) else $error("reserved bits set");
endmodule

// >>> bench/qoc_master_model.sv
// Purpose: Behavioural model of the masters that sit on the five slave interfaces.
// Assumes: Request QoS changes every cycle; outstanding state is steered by the bench.
// Notes: Outstanding state lags the hold request by one cycle, as a real drain would.
`timescale 1ns/10ps
module qoc_master_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] busy, // Interfaces with traffic in flight
  input wire logic [4:0] hold_out, // Interfaces keeping transactions outstanding
  input wire logic zero_req, // Send QoS zero on interface 0
  output logic [4:0] rd_idle,
  output logic [4:0] wr_idle,
  output logic [4:0] rd_none_out,
  output logic [4:0] wr_none_out,
  output logic [19:0] rd_req_qos,
  output logic [19:0] wr_req_qos
);
  int seed = 25; // Fixed seed keeps runs repeatable
  // ----------------------------------------------------------------
  // Idle follows the bench's traffic request directly
  // ----------------------------------------------------------------
  assign rd_idle = ~busy;
  assign wr_idle = ~busy;
  // New request QoS every cycle so a stale value never passes for a match
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_none_out <= 5'h1F;
      wr_none_out <= 5'h1F;
      rd_req_qos <= 20'h00000;
      wr_req_qos <= 20'h00000;
    end else begin
      // Zero QoS requests on interface 0 exercise the regulated value path; one write per signal per edge
      rd_req_qos <= 20'($random(seed)) & {16'hFFFF, {4{~zero_req}}};
      wr_req_qos <= 20'($random(seed)) & {16'hFFFF, {4{~zero_req}}};
      rd_none_out <= ~hold_out;
      wr_none_out <= ~hold_out;
    end
  end
endmodule

// >>> bench/qoc_regs_tb_top.sv
// Purpose: Self-checking bench for the QoS override and control register bank.
// Assumes: Five interfaces, 0 to 2 lite; read data stands one cycle after the strobe.
// Notes: Register data is random from a fixed seed; corner cases are written by hand.
`timescale 1ns/10ps
module qoc_regs_tb_top;
  import qoc_pkg::*;
  localparam logic [4:0] LITE = 5'h07; // Lite interfaces in this build
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_ff, rdat, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_secure = 1'b1, nonsec_allow = 1'b0, zero_req = 1'b0;
  logic [4:0] qos_force_input = 5'h00, busy = 5'h1F, hold_out = 5'h00;
  logic [19:0] rd_reg_qos = 20'h0, wr_reg_qos = 20'h0, rd_req_qos, wr_req_qos, rd_out_qos, wr_out_qos;
  logic [4:0] rd_idle, wr_idle, rd_none_out, wr_none_out, rd_ot_en, wr_ot_en;
  logic [4:0] qhigh_mode, rd_period_mode, wr_period_mode;
  logic [31:0] ns_rdata_ff, rdat_ns; // Read data of the build without regulation support
  logic [4:0] ns_qhigh; // Quiesce-high outputs of that build
  int err_total = 0, compares = 0, seed = 25;
  always #5 mclk = ~mclk;
  qoc_regs #(.N_IF(5), .LITE_MASK(LITE), .QOS_SUPPORTED(1'b1)) uut (.mclk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_secure, .nonsec_allow, .reg_rdata_ff, .qos_force_input, .rd_idle, .wr_idle,
    .rd_none_out, .wr_none_out, .rd_reg_qos, .wr_reg_qos, .rd_req_qos, .wr_req_qos, .rd_out_qos,
    .wr_out_qos, .rd_ot_en, .wr_ot_en, .qhigh_mode, .rd_period_mode, .wr_period_mode);
  // Second build without regulation support shares every input, so one sequence exercises both
  qoc_regs #(.N_IF(5), .LITE_MASK(LITE), .QOS_SUPPORTED(1'b0)) uut_ns (.mclk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_secure, .nonsec_allow, .reg_rdata_ff(ns_rdata_ff), .qos_force_input, .rd_idle,
    .wr_idle, .rd_none_out, .wr_none_out, .rd_reg_qos, .wr_reg_qos, .rd_req_qos, .wr_req_qos, .rd_out_qos(),
    .wr_out_qos(), .rd_ot_en(), .wr_ot_en(), .qhigh_mode(ns_qhigh), .rd_period_mode(), .wr_period_mode());
  qoc_master_model model (.mclk, .rst_n, .busy, .hold_out, .zero_req, .rd_idle, .wr_idle, .rd_none_out,
    .wr_none_out, .rd_req_qos, .wr_req_qos);
  // ----------------------------------------------------------------
  // Register port cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data is taken in the one cycle where it stands
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rdat = reg_rdata_ff;
    rdat_ns = ns_rdata_ff;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_qos(input logic [3:0] got, input logic [3:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Control read-back: reserved bits zero, support bit set, outstanding bits lite only
  function automatic logic [31:0] exp_ctrl(input int i, input logic [31:0] w);
    exp_ctrl = w & 32'h0031_0003;
    exp_ctrl[31] = 1'b1;
    if (LITE[i]) begin
      exp_ctrl[3:2] = w[3:2];
    end
  endfunction
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("CHECK FAILED %0t timeout", $time);
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4));
      chk_word(rdat, 32'h0, "rd ovr reset");
      rd(5'(i * 4 + 2));
      chk_word(rdat, 32'h8000_0000, "ctrl reset");
      chk_word(rdat_ns, 32'h0, "support bit clear");
      d = $random(seed);
      wr(5'(i * 4), d);
      rd(5'(i * 4));
      chk_word(rdat, {28'h0, d[3:0]}, "rd ovr");
      wr(5'(i * 4 + 1), ~d);
      rd(5'(i * 4 + 1));
      chk_word(rdat, {28'h0, ~d[3:0]}, "wr ovr");
      wr(5'(i * 4 + 2), d);
      rd(5'(i * 4 + 2));
      chk_word(rdat, exp_ctrl(i, d), "ctrl random");
      wr(5'(i * 4 + 2), 32'hFFFF_FFFF);
      rd(5'(i * 4 + 2));
      chk_word(rdat, exp_ctrl(i, 32'hFFFF_FFFF), "ctrl ones");
      chk_word(rdat_ns, 32'h0, "ctrl without support");
      chk_qos({3'h0, ns_qhigh[i]}, 4'h0, "mode without support");
      chk_qos({qhigh_mode[i], rd_period_mode[i], wr_period_mode[i], 1'b0}, 4'hE, "modes");
      chk_qos({rd_ot_en[i], wr_ot_en[i], 2'b0}, LITE[i] ? 4'hC : 4'h0, "ot enables");
      wr(5'(i * 4 + 2), 32'h0);
    end
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14);
    chk_word(rdat, 32'h0, "unmapped");
    rd(5'h03);
    chk_word(rdat, 32'h0, "offset 3");
    // Non-secure access refused, then allowed by the permission input
    @(posedge mclk);
    reg_secure <= 1'b0;
    wr(5'h00, 32'h5);
    rd(5'h00);
    chk_word(rdat, 32'h0, "nonsecure read");
    nonsec_allow <= 1'b1;
    wr(5'h00, 32'h6);
    rd(5'h00);
    chk_word(rdat, 32'h6, "allowed access");
    reg_secure <= 1'b1;
    nonsec_allow <= 1'b0;
    // Outstanding enable waits until interface 0 drains
    hold_out <= 5'h01;
    wr(5'h02, 32'h8);
    repeat (5) @(posedge mclk);
    #1;
    chk_qos({3'h0, rd_ot_en[0]}, 4'h0, "ot held");
    @(posedge mclk);
    hold_out <= 5'h00;
    repeat (3) @(posedge mclk);
    #1;
    chk_qos({3'h0, rd_ot_en[0]}, 4'h1, "ot after drain");
    // Forced override with regulation off, then force released
    wr(5'h01, 32'hA);
    qos_force_input <= 5'h01;
    repeat (4) @(posedge mclk);
    #1;
    chk_qos(rd_out_qos[3:0], 4'h6, "rd forced");
    chk_qos(wr_out_qos[3:0], 4'hA, "wr forced");
    qos_force_input <= 5'h00;
    repeat (4) @(posedge mclk);
    #1;
    chk_qos(rd_out_qos[3:0], rd_req_qos[3:0], "not forced");
    chk_qos(wr_out_qos[3:0], wr_req_qos[3:0], "wr not forced");
    // Regulation on: QoS-zero requests take the regulated value
    qos_force_input <= 5'h01;
    rd_reg_qos <= 20'h9;
    wr_reg_qos <= 20'h3;
    zero_req <= 1'b1;
    wr(5'h02, 32'h3);
    repeat (4) @(posedge mclk);
    #1;
    chk_qos(rd_out_qos[3:0], 4'h9, "rd regulated");
    chk_qos(wr_out_qos[3:0], 4'h3, "wr regulated");
    wr(5'h00, 32'hFFFF_F0F6);
    rd(5'h00);
    chk_word(rdat, 32'h906, "current value");
    // Idle master: normal mode holds, quiesce-high climbs to maximum
    busy <= 5'h00;
    repeat (40) @(posedge mclk);
    rd(5'h00);
    chk_word(rdat, 32'h906, "normal idle");
    wr(5'h02, 32'h0020_0003);
    repeat (272) @(posedge mclk);
    rd(5'h00);
    chk_word(rdat, 32'hF06, "quiesce high");
    test_done();
  end
endmodule
